// *** pkg/circ_defines.svh ***
// offsets, field positions, reset values and cycle counts of the interrupt/reset control
`ifndef CIRC_DEFINES_SVH
`define CIRC_DEFINES_SVH
`define CIRC_OFS_CMD 8'h00
`define CIRC_OFS_STATUS 8'h04
`define CIRC_OFS_CONTEXT 8'h08
`define CIRC_ST_MIE 0
`define CIRC_ST_XIE 1
`define CIRC_ST_CIE 2
`define CIRC_ST_CIL 3
`define CIRC_ST_EXT 4
`define CIRC_ST_BR 5
`define CIRC_ST_RUN 6
`define CIRC_ST_MODE 7
`define CIRC_ST_ETQ 9
`define CIRC_ST_Q 10
`define CIRC_CYCLE_CLKS 4'h8
`define CIRC_INIT_CLKS 4'h9
`define CIRC_TPA_PHASE 4'h1
`define CIRC_TPB_PHASE 4'h6
`define CIRC_IRQ_X 4'h2
`define CIRC_IRQ_P 4'h1
`define CIRC_SYNC_RST 3'h7
`endif

// *** pkg/circ_pkg.sv ***
// types of the interrupt/reset control
package circ_pkg;
	typedef enum logic [5:0] {
		ST_RESET = 6'h01,
		ST_INIT = 6'h02,
		ST_FETCH = 6'h04,
		ST_EXEC = 6'h08,
		ST_DMA = 6'h10,
		ST_INTR = 6'h20
	} circ_state_e;
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0,
		CMD_CIE_ON = 4'h1,
		CMD_CIE_OFF = 4'h2,
		CMD_XIE_ON = 4'h3,
		CMD_XIE_OFF = 4'h4,
		CMD_RESUME_ON = 4'h5,
		CMD_RESUME_OFF = 4'h6,
		CMD_BR_CNT = 4'h7,
		CMD_BR_EXT = 4'h8,
		CMD_LOAD_CNT = 4'h9,
		CMD_CNT_START = 4'ha,
		CMD_CNT_STOP = 4'hb,
		CMD_MODE_P1 = 4'hc,
		CMD_MODE_P2 = 4'hd,
		CMD_TOGGLE_ON = 4'he,
		CMD_MODE_TIMER = 4'hf
	} circ_cmd_e;
	typedef enum logic [1:0] {
		MODE_NONE = 2'h0,
		MODE_PULSE1 = 2'h1,
		MODE_PULSE2 = 2'h2,
		MODE_TIMER = 2'h3
	} circ_mode_e;
endpackage : circ_pkg

// *** rtl/circ_sync.sv ***
// two-flop synchroniser for the external interrupt and mode pins
`timescale 1ns/1ns
`include "circ_defines.svh"
module circ_sync (
	// clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// pins: interrupt_n, clear_n, wait_n
	input wire logic [2:0] async_in,
	output logic [2:0] sync_out
);
	logic [2:0] meta_reg;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			meta_reg <= `CIRC_SYNC_RST;
			sync_out <= `CIRC_SYNC_RST;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : circ_sync

// *** rtl/circ_top.sv ***
// interrupt generation, arbitration, reset and initialization cycle control
//
// Summary of operation
// - external request unlatched; counter requests latched
// - counter underflow from 01 sets latch
// - pulse mode 1/2 flag edge sets latch
// - service needs source enable and master enable
// - reset leaves all three enables set
// - commands set/clear each enable flip-flop
// - branches test pending requests ignoring enables
// - latch cleared by branch, reset, stopped load
// - latch still set re-enters interrupt
// - clear/wait pins select reset, pause, run
// - reset forces documented pin levels
// - reset clears opcode, latch, counter controls
// - init cycle lasts nine clocks in execute
// - init sets master, saves and clears designators
// - init suppresses service and request sampling; next always fetch
// - reset leaves datapath registers untouched
// - acknowledge saves context, sets 2/1, masks
// - priority DMA-in, then DMA-out, then interrupt
// - requests sampled at second pulse
`timescale 1ns/1ns
`include "circ_defines.svh"
module circ_top
	import circ_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// external pins
	input wire logic ext_irq_n_in,
	input wire logic clear_n_in,
	input wire logic wait_n_in,
	input wire logic event_flag_one_in,
	input wire logic event_flag_two_in,
	input wire logic dma_in_req_in,
	input wire logic dma_out_req_in,
	// counter datapath
	input wire logic counter_underflow_in,
	output logic counter_run_out,
	output logic [1:0] counter_mode_out,
	// core pin values, forced during reset
	input wire logic [7:0] core_data_in,
	input wire logic [7:0] core_addr_in,
	input wire logic [2:0] core_io_sel_in,
	input wire logic core_mrd_n_in,
	input wire logic core_mwr_n_in,
	input wire logic [7:0] register_zero_hi_in,
	// pins out
	output logic q_flag_out,
	output logic state_code_low_out,
	output logic state_code_high_out,
	output logic first_timing_pulse_out,
	output logic second_timing_pulse_out,
	output logic [7:0] data_bus_out,
	output logic [7:0] address_lines_out,
	output logic [2:0] io_select_lines_out,
	output logic memory_read_level_n_out,
	output logic memory_write_strobe_n_out,
	// core control
	output logic clear_instr_out,
	output logic clear_register_zero_out,
	output logic branch_taken_out,
	output logic dma_in_cycle_out,
	output logic [3:0] data_ptr_sel_out,
	output logic [3:0] prog_ctr_sel_out,
	output logic [7:0] saved_context_out
);
	logic [2:0] pins_sync;
	logic ext_req, pin_rst, hold, rst_all;
	circ_state_e state_reg, state_next;
	logic [3:0] phase_reg;
	logic cycle_end, tpb_now, ack_now, init_now;
	logic master_irq_enable, external_irq_enable, counter_irq_enable;
	logic counter_irq_latch, toggle_flag_on_underflow;
	logic irq_seen_reg, dma_in_seen_reg, dma_out_seen_reg;
	logic ef1_reg, ef2_reg, cnt_set, wr_cmd;
	circ_cmd_e cmd;
	circ_mode_e mode_reg;

	function automatic logic [3:0] cycle_last(input circ_state_e st);
		cycle_last = (st == ST_INIT) ? `CIRC_INIT_CLKS - 4'h1 : `CIRC_CYCLE_CLKS - 4'h1;
	endfunction : cycle_last

	function automatic circ_state_e next_cycle(input circ_state_e st, input logic din,
		input logic dout, input logic irq);
		unique case (st)
			ST_FETCH: next_cycle = ST_EXEC;
			ST_INIT: next_cycle = (din | dout) ? ST_DMA : ST_FETCH;
			ST_EXEC, ST_DMA: next_cycle = (din | dout) ? ST_DMA : (irq ? ST_INTR : ST_FETCH);
			ST_INTR: next_cycle = (din | dout) ? ST_DMA : ST_FETCH;
			default: next_cycle = ST_INIT;
		endcase
	endfunction : next_cycle

	circ_sync u_sync (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.async_in({ext_irq_n_in, clear_n_in, wait_n_in}),
		.sync_out(pins_sync)
	);

	// level only, never stored: the far end holds it until polled
	assign ext_req = ~pins_sync[2];
	assign pin_rst = ~pins_sync[1] & pins_sync[0];
	// both-low is not allowed; treated like pause so nothing advances
	assign hold = ~pins_sync[0];
	assign rst_all = srst_in | pin_rst;
	assign cycle_end = (phase_reg == cycle_last(state_reg)) && !hold;
	assign tpb_now = (phase_reg == `CIRC_TPB_PHASE) && !hold;
	assign ack_now = (state_reg == ST_INTR) && (phase_reg == 4'h0) && !hold;
	assign init_now = (state_reg == ST_INIT) && (phase_reg == 4'h0) && !hold;
	assign wr_cmd = reg_wr_in && (reg_addr_in == `CIRC_OFS_CMD);
	assign cmd = wr_cmd ? circ_cmd_e'(reg_wdata_in[3:0]) : CMD_NONE;
	assign state_next = next_cycle(state_reg, dma_in_seen_reg, dma_out_seen_reg, irq_seen_reg);

	// machine cycle sequencer
	always_ff @(posedge clk_in) begin
		if (rst_all) begin
			state_reg <= ST_RESET;
			phase_reg <= 4'h0;
		end else if (state_reg == ST_RESET) begin
			state_reg <= ST_INIT;
			phase_reg <= 4'h0;
		end else if (cycle_end) begin
			state_reg <= state_next;
			phase_reg <= 4'h0;
		end else if (!hold) begin
			phase_reg <= phase_reg + 4'h1;
		end
	end

	// request sampling at the second timing pulse
	always_ff @(posedge clk_in) begin
		if (rst_all || cycle_end) begin
			irq_seen_reg <= 1'b0;
			dma_in_seen_reg <= 1'b0;
			dma_out_seen_reg <= 1'b0;
		end else if (tpb_now && (state_reg != ST_INIT)) begin
			if (state_reg == ST_EXEC || state_reg == ST_DMA) begin
				irq_seen_reg <= master_irq_enable &&
					((ext_req && external_irq_enable) || (counter_irq_latch && counter_irq_enable));
			end
			if (state_reg != ST_FETCH) begin
				dma_in_seen_reg <= dma_in_req_in;
				dma_out_seen_reg <= dma_out_req_in;
			end
		end
	end

	// enable flip-flops; acknowledge outranks a software write in the same clock
	always_ff @(posedge clk_in) begin
		if (rst_all) begin
			master_irq_enable <= 1'b1;
			external_irq_enable <= 1'b1;
			counter_irq_enable <= 1'b1;
		end else begin
			if (ack_now) begin
				master_irq_enable <= 1'b0;
			end else if (init_now) begin
				master_irq_enable <= 1'b1;
			end else if (cmd == CMD_RESUME_ON) begin
				master_irq_enable <= 1'b1;
			end else if (cmd == CMD_RESUME_OFF) begin
				master_irq_enable <= 1'b0;
			end
			if (cmd == CMD_XIE_ON) begin
				external_irq_enable <= 1'b1;
			end else if (cmd == CMD_XIE_OFF) begin
				external_irq_enable <= 1'b0;
			end
			if (cmd == CMD_CIE_ON) begin
				counter_irq_enable <= 1'b1;
			end else if (cmd == CMD_CIE_OFF) begin
				counter_irq_enable <= 1'b0;
			end
		end
	end

	// counter request latch; a new event beats any software clear in the same clock
	always_ff @(posedge clk_in) begin
		if (rst_all) begin
			ef1_reg <= 1'b0;
			ef2_reg <= 1'b0;
		end else begin
			ef1_reg <= event_flag_one_in;
			ef2_reg <= event_flag_two_in;
		end
	end
	assign cnt_set = counter_run_out && (counter_underflow_in ||
		(mode_reg == MODE_PULSE1 && ef1_reg && !event_flag_one_in) ||
		(mode_reg == MODE_PULSE2 && ef2_reg && !event_flag_two_in));

	always_ff @(posedge clk_in) begin
		if (rst_all) begin
			counter_irq_latch <= 1'b0;
		end else if (cnt_set) begin
			counter_irq_latch <= 1'b1;
		end else if ((cmd == CMD_BR_CNT) || (cmd == CMD_LOAD_CNT && !counter_run_out)) begin
			counter_irq_latch <= 1'b0;
		end
	end

	// counter controls; the count value itself lives outside and is never touched
	always_ff @(posedge clk_in) begin
		if (rst_all) begin
			counter_run_out <= 1'b0;
			mode_reg <= MODE_NONE;
			toggle_flag_on_underflow <= 1'b0;
		end else begin
			if (cmd == CMD_CNT_START) begin
				counter_run_out <= 1'b1;
			end else if (cmd == CMD_CNT_STOP) begin
				counter_run_out <= 1'b0;
			end
			if (cmd == CMD_MODE_P1) begin
				mode_reg <= MODE_PULSE1;
			end else if (cmd == CMD_MODE_P2) begin
				mode_reg <= MODE_PULSE2;
			end else if (cmd == CMD_MODE_TIMER) begin
				mode_reg <= MODE_TIMER;
			end
			if (cmd == CMD_TOGGLE_ON) begin
				toggle_flag_on_underflow <= 1'b1;
			end else if ((cmd == CMD_BR_CNT && counter_irq_latch) ||
				(cmd == CMD_LOAD_CNT && !counter_run_out)) begin
				toggle_flag_on_underflow <= 1'b0;
			end
		end
	end
	assign counter_mode_out = mode_reg;

	// branch result: pending requests only, enables ignored
	always_ff @(posedge clk_in) begin
		if (rst_all) begin
			branch_taken_out <= 1'b0;
		end else begin
			branch_taken_out <= ((cmd == CMD_BR_CNT) && counter_irq_latch) ||
				((cmd == CMD_BR_EXT) && ext_req);
		end
	end

	// designators and saved context: no reset, old values survive until init
	logic [3:0] x_reg, p_reg;
	logic [7:0] t_reg;
	always_ff @(posedge clk_in) begin
		if (!rst_all && (init_now || ack_now)) begin
			t_reg <= {x_reg, p_reg};
			x_reg <= init_now ? 4'h0 : `CIRC_IRQ_X;
			p_reg <= init_now ? 4'h0 : `CIRC_IRQ_P;
		end else if (!rst_all && reg_wr_in && (reg_addr_in == `CIRC_OFS_CONTEXT)) begin
			x_reg <= reg_wdata_in[7:4];
			p_reg <= reg_wdata_in[3:0];
		end
	end
	assign data_ptr_sel_out = x_reg;
	assign prog_ctr_sel_out = p_reg;
	assign saved_context_out = t_reg;

	// pin stage: core values pass one clock late, forced while reset holds
	always_ff @(posedge clk_in) begin
		if (rst_all) begin
			q_flag_out <= 1'b0;
			state_code_high_out <= 1'b0;
			state_code_low_out <= 1'b1;
			first_timing_pulse_out <= 1'b0;
			second_timing_pulse_out <= 1'b0;
			data_bus_out <= 8'h00;
			address_lines_out <= register_zero_hi_in;
			io_select_lines_out <= 3'h0;
			memory_read_level_n_out <= 1'b1;
			memory_write_strobe_n_out <= 1'b1;
			clear_instr_out <= 1'b1;
		end else begin
			if (toggle_flag_on_underflow && counter_underflow_in) begin
				q_flag_out <= ~q_flag_out;
			end
			state_code_high_out <= (state_reg == ST_DMA) || (state_reg == ST_INTR);
			state_code_low_out <= (state_reg == ST_EXEC) || (state_reg == ST_INIT) ||
				(state_reg == ST_INTR) || (state_reg == ST_RESET);
			first_timing_pulse_out <= (phase_reg == `CIRC_TPA_PHASE) && (state_reg != ST_RESET);
			second_timing_pulse_out <= (phase_reg == `CIRC_TPB_PHASE) && (state_reg != ST_RESET);
			data_bus_out <= core_data_in;
			address_lines_out <= core_addr_in;
			io_select_lines_out <= core_io_sel_in;
			memory_read_level_n_out <= core_mrd_n_in;
			memory_write_strobe_n_out <= core_mwr_n_in;
			clear_instr_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_all) begin
			clear_register_zero_out <= 1'b0;
			dma_in_cycle_out <= 1'b0;
		end else begin
			clear_register_zero_out <= init_now;
			dma_in_cycle_out <= cycle_end && (state_next == ST_DMA) ? dma_in_seen_reg :
				(cycle_end ? 1'b0 : dma_in_cycle_out);
		end
	end

	// register reads answer one clock later, zero otherwise
	always_ff @(posedge clk_in) begin
		if (srst_in || !reg_rd_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_addr_in == `CIRC_OFS_STATUS) begin
			reg_rdata_out <= 16'h0000;
			reg_rdata_out[`CIRC_ST_MIE] <= master_irq_enable;
			reg_rdata_out[`CIRC_ST_XIE] <= external_irq_enable;
			reg_rdata_out[`CIRC_ST_CIE] <= counter_irq_enable;
			reg_rdata_out[`CIRC_ST_CIL] <= counter_irq_latch;
			reg_rdata_out[`CIRC_ST_EXT] <= ext_req;
			reg_rdata_out[`CIRC_ST_BR] <= branch_taken_out;
			reg_rdata_out[`CIRC_ST_RUN] <= counter_run_out;
			reg_rdata_out[`CIRC_ST_MODE +: 2] <= mode_reg;
			reg_rdata_out[`CIRC_ST_ETQ] <= toggle_flag_on_underflow;
			reg_rdata_out[`CIRC_ST_Q] <= q_flag_out;
		end else if (reg_addr_in == `CIRC_OFS_CONTEXT) begin
			reg_rdata_out <= {t_reg, x_reg, p_reg};
		end else begin
			reg_rdata_out <= 16'h0000;
		end
	end

	logic in_init;
	assign in_init = (state_reg == ST_INIT);

	// init clocks counted here so the length check needs no long repetition
	logic [3:0] init_len_reg;
	always_ff @(posedge clk_in) begin
		if (rst_all || !in_init) begin
			init_len_reg <= 4'h0;
		end else if (!hold) begin
			init_len_reg <= init_len_reg + 4'h1;
		end
	end

	sequence seq_init_run;
		init_len_reg == `CIRC_INIT_CLKS;
	endsequence
	sequence seq_init_exit;
		!in_init && (state_reg == ST_FETCH || state_reg == ST_DMA);
	endsequence

	chk_cil_underflow: assert property (@(posedge clk_in) disable iff (rst_all)
		counter_run_out && counter_underflow_in |=> counter_irq_latch)
		else $error("underflow did not set counter latch");
	chk_pulse_edge: assert property (@(posedge clk_in) disable iff (rst_all)
		mode_reg == MODE_PULSE1 && counter_run_out && $fell(event_flag_one_in) |=> counter_irq_latch)
		else $error("flag edge did not set counter latch");
	chk_reset_enables: assert property (@(posedge clk_in)
		srst_in |=> master_irq_enable && external_irq_enable && counter_irq_enable && !counter_irq_latch)
		else $error("reset left an enable clear");
	chk_branch_clears: assert property (@(posedge clk_in) disable iff (rst_all)
		cmd == CMD_BR_CNT && counter_irq_latch && !cnt_set |=> !counter_irq_latch && branch_taken_out)
		else $error("counter branch did not clear latch");
	chk_init_length: assert property (@(posedge clk_in) disable iff (rst_all || hold)
		$fell(in_init) && state_reg != ST_RESET |-> seq_init_run ##0 seq_init_exit)
		else $error("init cycle not nine clocks");
	chk_init_exit: assert property (@(posedge clk_in) disable iff (rst_all)
		$fell(in_init) |-> seq_init_exit)
		else $error("init followed by execute or interrupt");
	chk_irq_ack: assert property (@(posedge clk_in) disable iff (rst_all)
		$rose(state_reg == ST_INTR) |=> x_reg == 4'h2 && p_reg == 4'h1 && !master_irq_enable)
		else $error("acknowledge did not set designators");
	chk_dma_first: assert property (@(posedge clk_in) disable iff (rst_all)
		cycle_end && state_reg == ST_EXEC && dma_in_seen_reg |=> state_reg == ST_DMA)
		else $error("interrupt beat DMA");
	chk_gate_mie: assert property (@(posedge clk_in) disable iff (rst_all)
		tpb_now && !master_irq_enable && !cycle_end |=> !irq_seen_reg)
		else $error("interrupt sampled while masked");
	chk_reset_pins: assert property (@(posedge clk_in)
		rst_all |=> memory_read_level_n_out && memory_write_strobe_n_out && state_code_low_out &&
			!state_code_high_out && !first_timing_pulse_out && !q_flag_out)
		else $error("reset pin levels wrong");
endmodule : circ_top

// *** testbench/circ_io_partner.sv ***
// far-side model: external interrupt source and clear/wait mode pins
`timescale 1ns/1ns
module circ_io_partner (
	// clock
	input wire logic clk_in,
	// requests from the bench
	input wire logic raise_in,
	input wire logic [1:0] mode_in,
	input wire logic branch_seen_in,
	// pins
	output logic ext_irq_n_out,
	output logic clear_n_out,
	output logic wait_n_out
);
	logic pending_reg;

	// the request stays up until software has identified it by a branch or mode 0 selects reset
	always_ff @(posedge clk_in) begin
		if (raise_in)
			pending_reg <= 1'b1;
		else if (branch_seen_in || mode_in == 2'h0)
			pending_reg <= 1'b0;
	end

	assign ext_irq_n_out = ~pending_reg;
	// mode 0 reset, 1 pause, 2 run; both low is never driven
	assign clear_n_out = (mode_in != 2'h0);
	assign wait_n_out = (mode_in != 2'h1);
endmodule : circ_io_partner

// *** testbench/tb.sv ***
// self-checking bench for the interrupt/reset control
`timescale 1ns/1ns
`include "circ_defines.svh"
module tb
	import circ_pkg::*;
;
	logic clk_in, srst_in, reg_wr_in, reg_rd_in;
	logic [7:0] reg_addr_in;
	logic [15:0] reg_wdata_in, reg_rdata_out, d;
	logic ext_irq_n, clear_n, wait_n, flag1, flag2, dma_in, dma_out, underflow, raise;
	logic run, q, scl, sch, first_timing_pulse, second_timing_pulse, mrd_n, mwr_n, clr_instr, clr_r0, br, din;
	logic [1:0] mode, pin_mode;
	logic [7:0] bus, addr, saved, r0hi;
	logic [2:0] io;
	logic [3:0] xsel, psel;
	logic s10, s11, sdin;
	int mismatches, checks_done, k;
	logic [3:0] en_cmd [6] = '{4'h2, 4'h1, 4'h4, 4'h3, 4'h6, 4'h5};
	logic [15:0] en_exp [6] = '{16'h0003, 16'h0007, 16'h0005, 16'h0007, 16'h0006, 16'h0007};

	circ_top i_circ_top (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.ext_irq_n_in(ext_irq_n), .clear_n_in(clear_n), .wait_n_in(wait_n), .event_flag_one_in(flag1),
		.event_flag_two_in(flag2), .dma_in_req_in(dma_in), .dma_out_req_in(dma_out),
		.counter_underflow_in(underflow), .counter_run_out(run), .counter_mode_out(mode),
		.core_data_in(8'h5a), .core_addr_in(8'h12), .core_io_sel_in(3'h5), .core_mrd_n_in(1'b0),
		.core_mwr_n_in(1'b0), .register_zero_hi_in(r0hi), .q_flag_out(q), .state_code_low_out(scl),
		.state_code_high_out(sch), .first_timing_pulse_out(first_timing_pulse), .second_timing_pulse_out(second_timing_pulse),
		.data_bus_out(bus), .address_lines_out(addr), .io_select_lines_out(io),
		.memory_read_level_n_out(mrd_n), .memory_write_strobe_n_out(mwr_n), .clear_instr_out(clr_instr),
		.clear_register_zero_out(clr_r0), .branch_taken_out(br), .dma_in_cycle_out(din),
		.data_ptr_sel_out(xsel), .prog_ctr_sel_out(psel), .saved_context_out(saved));

	circ_io_partner i_circ_io_partner (.clk_in(clk_in), .raise_in(raise), .mode_in(pin_mode),
		.branch_seen_in(br), .ext_irq_n_out(ext_irq_n), .clear_n_out(clear_n), .wait_n_out(wait_n));

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		v = reg_rdata_out;
	endtask : rd

	task automatic cmd(input logic [3:0] c);
		wr(`CIRC_OFS_CMD, {12'h000, c});
		#1;
	endtask : cmd

	task automatic st(input logic [15:0] mask, input logic [15:0] exp, input string what);
		rd(`CIRC_OFS_STATUS, d);
		check(d & mask, exp, what);
	endtask : st

	// one-cycle high on {underflow, flag2, flag1}; a flag counts on its fall
	task automatic strobe(input logic [2:0] f);
		@(posedge clk_in);
		{underflow, flag2, flag1} <= f;
		@(posedge clk_in);
		{underflow, flag2, flag1} <= 3'h0;
	endtask : strobe

	// lets a running acknowledge pass, then watches the state code
	task automatic watch(input int n);
		s10 = 1'b0;
		s11 = 1'b0;
		#1;
		for (int i = 0; i < 12 && {sch, scl} === 2'h3; i++) begin
			@(posedge clk_in);
			#1;
		end
		for (int i = 0; i < n && s11 === 1'b0; i++) begin
			@(posedge clk_in);
			#1;
			if ({sch, scl} === 2'h2) begin
				s10 = 1'b1;
				sdin = din;
			end
			s11 = ({sch, scl} === 2'h3);
		end
	endtask : watch

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test

	// whole run is a few hundred cycles
	initial begin
		#100000;
		mismatches++;
		finish_test();
	end

	initial begin
		srst_in = 1'b1;
		{reg_wr_in, reg_rd_in, raise, underflow, flag1, flag2, dma_in, dma_out} = 8'h00;
		reg_addr_in = 8'h00;
		reg_wdata_in = 16'h0000;
		pin_mode = 2'h0;
		r0hi = 8'hc3;
		repeat (4) @(posedge clk_in);
		pin_mode <= 2'h2;
		repeat (7) @(posedge clk_in);
		#1;
		check({q, sch, scl, first_timing_pulse, second_timing_pulse, bus, io}, 16'h2000, "pins in reset");
		check({mrd_n, mwr_n, addr}, 16'h03c3, "strobes and address in reset");
		check({clr_instr, run, mode}, 16'h0008, "core controls in reset");
		@(posedge clk_in);
		srst_in <= 1'b0;
		k = 0;
		for (int i = 0; i < 9; i++) begin
			@(posedge clk_in);
			#1;
			k += clr_r0;
			check({sch, scl}, 2'h1, "state code in init");
		end
		for (int i = 0; i < 4 && {sch, scl} === 2'h1; i++) begin
			@(posedge clk_in);
			#1;
		end
		check({sch, scl}, 2'h0, "cycle after init");
		check(k, 1, "register zero clear pulse");
		check({xsel, psel}, 8'h00, "designators cleared");
		check({bus, addr}, 16'h5a12, "core data and address pass");
		check({io, mrd_n, mwr_n}, 16'h0014, "core select and strobes pass");
		st(16'h000f, 16'h0007, "enables after reset");
		rd(8'h40, d);
		check(d, 16'h0000, "unmapped read");
		$display("test reset done");

		foreach (en_cmd[i]) begin
			cmd(en_cmd[i]);
			st(16'h0007, en_exp[i], "enable command");
		end
		cmd(4'h6);
		cmd(4'h2);
		cmd(4'h4);
		@(posedge clk_in);
		raise <= 1'b1;
		@(posedge clk_in);
		raise <= 1'b0;
		repeat (4) @(posedge clk_in);
		st(16'h0010, 16'h0010, "external pending");
		cmd(4'h7);
		check(br, 1'b0, "counter branch idle");
		cmd(4'h8);
		check(br, 1'b1, "external branch with enables off");
		repeat (4) @(posedge clk_in);
		st(16'h0010, 16'h0000, "external not latched");
		cmd(4'h1);
		cmd(4'h3);
		$display("test enables and polling done");

		cmd(4'ha);
		check(run, 1'b1, "counter started");
		strobe(3'h4);
		repeat (4) @(posedge clk_in);
		st(16'h0008, 16'h0008, "latch on underflow");
		cmd(4'h7);
		check(br, 1'b1, "counter branch taken");
		st(16'h0008, 16'h0000, "latch cleared by branch");
		cmd(4'hc);
		check(mode, MODE_PULSE1, "pulse mode one");
		strobe(3'h1);
		st(16'h0008, 16'h0008, "latch on flag one");
		cmd(4'hb);
		cmd(4'h9);
		st(16'h0008, 16'h0000, "latch cleared by stopped load");
		cmd(4'hd);
		cmd(4'ha);
		strobe(3'h1);
		st(16'h0008, 16'h0000, "flag one ignored in mode two");
		strobe(3'h2);
		st(16'h0008, 16'h0008, "latch on flag two");
		cmd(4'he);
		strobe(3'h4);
		#1;
		check(q, 1'b1, "q toggles on underflow");
		st(16'h0208, 16'h0208, "toggle enabled, latch set");
		cmd(4'h7);
		st(16'h0208, 16'h0000, "branch clears toggle and latch");
		cmd(4'hf);
		check(mode, MODE_TIMER, "timer mode");
		strobe(3'h4);
		#1;
		check(q, 1'b1, "q steady with toggle off");
		st(16'h0008, 16'h0008, "latch on underflow in timer mode");
		$display("test counter latch done");

		wr(`CIRC_OFS_CONTEXT, 16'h0035);
		cmd(4'h2);
		cmd(4'h5);
		watch(40);
		check(s11, 1'b0, "counter request masked");
		cmd(4'h1);
		watch(40);
		check(s11, 1'b1, "counter interrupt taken");
		repeat (2) @(posedge clk_in);
		#1;
		check({xsel, psel, saved}, 16'h2135, "acknowledge designators");
		st(16'h0001, 16'h0000, "master cleared by acknowledge");
		cmd(4'h5);
		watch(40);
		check(s11, 1'b1, "re-entry with latch set");
		cmd(4'h7);
		check(br, 1'b1, "branch in service routine");
		cmd(4'h5);
		watch(40);
		check(s11, 1'b0, "no re-entry after branch");
		$display("test interrupt done");

		cmd(4'h6);
		@(posedge clk_in);
		raise <= 1'b1;
		dma_in <= 1'b1;
		@(posedge clk_in);
		raise <= 1'b0;
		cmd(4'h5);
		watch(40);
		check({s10, s11, sdin}, 3'h5, "dma-in over interrupt");
		@(posedge clk_in);
		dma_in <= 1'b0;
		dma_out <= 1'b1;
		watch(40);
		check({s10, s11, sdin}, 3'h4, "dma-out over interrupt");
		@(posedge clk_in);
		dma_out <= 1'b0;
		watch(40);
		check(s11, 1'b1, "interrupt after dma");
		cmd(4'h8);
		check(br, 1'b1, "external branch after service");
		$display("test priority done");

		@(posedge clk_in);
		pin_mode <= 2'h0;
		r0hi <= 8'h3c;
		repeat (6) @(posedge clk_in);
		#1;
		check({sch, scl, clr_instr, addr}, 16'h033c, "pin reset");
		@(posedge clk_in);
		pin_mode <= 2'h1;
		repeat (4) @(posedge clk_in);
		k = 0;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_in);
			#1;
			k += (first_timing_pulse | second_timing_pulse);
		end
		check(k, 0, "pause holds timing");
		pin_mode <= 2'h2;
		repeat (20) @(posedge clk_in);
		st(16'h07cf, 16'h0007, "state after pin reset");
		$display("test pin modes done");
		finish_test();
	end
endmodule : tb
